// file: bcc_params.svh
// Constants for the block check generator and checker.
// Behaviour
// - Generate a 16-bit check word per block with polynomial x16+x15+x2+1.
// - Separate check words for header and data, each right after its block.
// - Feed bits LSB of first byte first; first bit is highest-order term.
// - Dividend is block followed by sixteen zero bits (block times x16).
// - Highest degree 63 for header, eight times count plus fifteen for data.
// - Modulo-2 division by XOR; keep 16-bit remainder, drop quotient.
// - Send remainder x15 first: byte one x8..x15, byte two x0..x7.
// - On receive compare recomputed check with received bytes; flag difference.
// - Alternatively divide including check bytes; nonzero remainder is an error.
// - Byte-parallel result equals serial; first byte LSB is highest term.
// - Flag every burst error of sixteen bits or fewer.
// - Flag every error inverting an odd number of bits.
`ifndef BCC_PARAMS_SVH
`define BCC_PARAMS_SVH
`define BCC_W         16
`define BCC_POLY      16'h8005
`define BCC_POLY_REFL 16'hA001
`define BCC_ZERO      16'h0000
`define BCC_HDR_BYTES 6
`define BCC_MAX_COUNT 4093
`endif

// file: bcc_pkg.sv
// Types shared by the block check generator and checker.
package bcc_pkg;
	// One byte offered by the framing logic.
	typedef struct packed {
		logic       valid;
		logic       last;
		logic       is_data;
		logic [7:0] data;
	} bcc_byte_t;
	// Result of a receive check.
	typedef struct packed {
		logic        done;
		logic        err_cmp;
		logic        err_rem;
		logic [15:0] word;
	} bcc_result_t;
	typedef enum logic [1:0] {
		BCC_IDLE,
		BCC_BODY,
		BCC_CK1,
		BCC_CK2
	} bcc_state_t;
endpackage

// file: bcc_step.sv
// One byte step of the block check remainder.
`timescale 1ns/1ps
`include "bcc_params.svh"
module bcc_step (
	// Remainder in and byte in.
	input  wire logic [15:0] rem_in,
	input  wire logic [7:0]  byte_in,
	// Remainder after eight bits.
	output logic      [15:0] rem_out
);
	// Reflected register: bit 15-k holds the x^k coefficient, so a right shift raises degree.
	function automatic logic [15:0] step8(input logic [15:0] r, input logic [7:0] b);
		logic [15:0] x;
		logic        fb;
		x = r;
		for (int i = 0; i < 8; i++) begin
			fb = x[0] ^ b[i];
			x  = {1'b0, x[15:1]};
			if (fb) begin
				x = x ^ `BCC_POLY_REFL;
			end
		end
		return x;
	endfunction

	// Byte-parallel form of the serial division.
	assign rem_out = step8(rem_in, byte_in);
endmodule

// file: bcc_crc16.sv
// Block check generator and checker for header and data blocks.
`timescale 1ns/1ps
`include "bcc_params.svh"
module bcc_crc16 (
	// Clock, reset and enable.
	input  wire logic             mclk,
	input  wire logic             srst,
	input  wire logic             ce,
	// Mode: high checks received blocks, low generates.
	input  wire logic             rx_mode,
	// Byte stream from framing.
	input  wire bcc_pkg::bcc_byte_t in_byte,
	output logic                  in_ready,
	// Transmit check bytes.
	output logic                  ck_valid,
	output logic [7:0]            ck_byte,
	output logic                  ck_last,
	input  wire logic             ck_ready,
	// Receive result.
	output bcc_pkg::bcc_result_t  result
);
	bcc_pkg::bcc_state_t st_q, st_d;
	logic [15:0] rem_q, rem_d, step_out, hold_q, hold_d;
	logic [15:0] rx_ck_q, rx_ck_d;
	logic [7:0]  ck_byte_q;
	logic        rx_q;
	bcc_pkg::bcc_result_t res_q, res_d;
	logic [15:0] sent_word;
	wire         take = ce && in_byte.valid && in_ready;

	// Byte step.
	bcc_step u_step (
		.rem_in  (st_q == bcc_pkg::BCC_IDLE ? `BCC_ZERO : rem_q),
		.byte_in (in_byte.data),
		.rem_out (step_out)
	);

	// Reorder so bit 15 is x^15 for output.
	assign sent_word = {<<{hold_q}};

	// Handshakes: body accepted in idle/body; in rx mode check bytes are also input.
	assign in_ready = (st_q == bcc_pkg::BCC_IDLE) || (st_q == bcc_pkg::BCC_BODY) ||
	                  (rx_q && (st_q == bcc_pkg::BCC_CK1 || st_q == bcc_pkg::BCC_CK2));
	assign ck_valid = !rx_q && (st_q == bcc_pkg::BCC_CK1 || st_q == bcc_pkg::BCC_CK2);
	assign ck_byte  = ck_byte_q;
	assign ck_last  = st_q == bcc_pkg::BCC_CK2;
	assign result   = res_q;

	// Next-state logic.
	always_comb begin
		st_d    = st_q;
		rem_d   = rem_q;
		hold_d  = hold_q;
		rx_ck_d = rx_ck_q;
		res_d   = res_q;
		res_d.done = 1'b0;
		case (st_q)
			bcc_pkg::BCC_IDLE, bcc_pkg::BCC_BODY: begin
				if (take) begin
					rem_d = step_out;
					st_d  = bcc_pkg::BCC_BODY;
					if (in_byte.last) begin
						hold_d = step_out;
						st_d   = bcc_pkg::BCC_CK1;
					end
				end
			end
			bcc_pkg::BCC_CK1: begin
				if (rx_q && take) begin
					rx_ck_d[15:8] = in_byte.data;
					rem_d         = step_out;
					st_d          = bcc_pkg::BCC_CK2;
				end else if (!rx_q && ce && ck_ready) begin
					st_d = bcc_pkg::BCC_CK2;
				end
			end
			default: begin
				if (rx_q && take) begin
					res_d.done    = 1'b1;
					res_d.word    = sent_word;
					// First received byte carries the low half of the reflected register.
					res_d.err_cmp = {in_byte.data, rx_ck_q[15:8]} != hold_q;
					res_d.err_rem = step_out != `BCC_ZERO;
					rem_d         = `BCC_ZERO;
					st_d          = bcc_pkg::BCC_IDLE;
				end else if (!rx_q && ce && ck_ready) begin
					rem_d = `BCC_ZERO;
					st_d  = bcc_pkg::BCC_IDLE;
				end
			end
		endcase
	end

	// State registers.
	always_ff @(posedge mclk) begin
		if (srst) begin
			st_q      <= bcc_pkg::BCC_IDLE;
			rem_q     <= `BCC_ZERO;
			hold_q    <= `BCC_ZERO;
			rx_ck_q   <= `BCC_ZERO;
			res_q     <= '0;
			rx_q      <= 1'b0;
			ck_byte_q <= 8'h00;
		end else if (ce) begin
			st_q    <= st_d;
			rem_q   <= rem_d;
			hold_q  <= hold_d;
			rx_ck_q <= rx_ck_d;
			res_q   <= res_d;
			if (st_q == bcc_pkg::BCC_IDLE) begin
				rx_q <= rx_mode;
			end
			if (st_d == bcc_pkg::BCC_CK1) begin
				ck_byte_q <= hold_d[7:0];
			end else if (st_d == bcc_pkg::BCC_CK2) begin
				ck_byte_q <= hold_q[15:8];
			end
		end
	end

	// Check bytes carry x^15 first, x^8..x^15 in byte one.
	a_ck_order: assert property (@(posedge mclk) disable iff (srst)
		(ck_valid && !ck_last && ce && ck_ready) |=> (ck_byte == hold_q[15:8]))
		else $error("second check byte wrong");
	// Remainder clears after each block.
	a_rem_clear: assert property (@(posedge mclk) disable iff (srst)
		(ce && st_q == bcc_pkg::BCC_CK2 && st_d == bcc_pkg::BCC_IDLE) |=> rem_q == `BCC_ZERO)
		else $error("remainder not cleared");
	// Check bytes follow the last byte.
	a_ck_follow: assert property (@(posedge mclk) disable iff (srst)
		(take && in_byte.last && st_q != bcc_pkg::BCC_CK1 && st_q != bcc_pkg::BCC_CK2 &&
		 !(st_q == bcc_pkg::BCC_IDLE ? rx_mode : rx_q))
		|=> ck_valid && !ck_last)
		else $error("check byte missing");
	// Both receive checks agree.
	a_rx_agree: assert property (@(posedge mclk) disable iff (srst)
		res_q.done |-> res_q.err_cmp == res_q.err_rem)
		else $error("receive checks disagree");
	// The done flag stands for one enabled cycle only.
	a_done_pulse: assert property (@(posedge mclk) disable iff (srst)
		(ce && res_q.done) |=> !res_q.done)
		else $error("done flag held too long");
	// Body bytes are refused while transmit check bytes are pending.
	a_tx_refuse: assert property (@(posedge mclk) disable iff (srst)
		(!rx_q && (st_q == bcc_pkg::BCC_CK1 || st_q == bcc_pkg::BCC_CK2)) |-> !in_ready)
		else $error("byte accepted during check bytes");
endmodule

// file: bcc_framer.sv
// Framing-side model that offers bytes and drains check bytes.
`timescale 1ns/1ps
module bcc_framer (
	// Clock, taker ready and stall request.
	input  wire logic          mclk,
	input  wire logic          in_ready,
	input  wire logic          stall,
	// Byte offered and drain strobe.
	output bcc_pkg::bcc_byte_t in_byte,
	output logic               ck_ready
);
	initial in_byte = '0;
	initial ck_ready = 1'b1;
	// The drain strobe toggles while stalling, so check bytes must wait.
	always @(posedge mclk) ck_ready <= #1 stall ? ~ck_ready : 1'b1;
	// Offers one byte and holds it until taken; returns just after the taking edge.
	task automatic send(input logic [7:0] b, input logic lst);
		logic r;
		in_byte = {1'b1, lst, 1'b0, b};
		do begin
			r = in_ready;
			@(posedge mclk);
		end while (r !== 1'b1);
		#1;
	endtask
	// Withdraws the offer and shows the inverse of the last byte.
	task automatic drop;
		in_byte = {3'h0, ~in_byte.data};
	endtask
endmodule

// file: tb.sv
// Self-checking bench for the block check generator and checker.
`timescale 1ns/1ps
module tb;
	logic mclk = 0, srst = 1, ce = 1, rx_mode = 0, stall = 0, in_ready, ck_valid, ck_last, ck_ready;
	logic [7:0] ck_byte;
	bcc_pkg::bcc_byte_t in_byte;
	bcc_pkg::bcc_result_t result;
	int n_mismatch = 0, n_checks = 0;
	logic [7:0] msg [6] = '{8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36};
	bcc_crc16 bcc_crc16_i (.mclk(mclk), .srst(srst), .ce(ce), .rx_mode(rx_mode), .in_byte(in_byte),
		.in_ready(in_ready), .ck_valid(ck_valid), .ck_byte(ck_byte), .ck_last(ck_last),
		.ck_ready(ck_ready), .result(result));
	bcc_framer bcc_framer_i (.mclk(mclk), .in_ready(in_ready), .stall(stall), .in_byte(in_byte),
		.ck_ready(ck_ready));
	always #50 mclk = ~mclk;
	// Reference remainder: serial shift, first byte LSB as highest term.
	function automatic logic [15:0] ref_crc(input int n);
		logic [15:0] c = 16'h0000;
		for (int i = 0; i < n; i++) begin
			c ^= {8'h00, msg[i]};
			for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
		end
		return c;
	endfunction
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask
	// Generates a block and collects the two check bytes.
	task automatic tx_block(input int n, input logic stl);
		logic [7:0] got [2];
		logic lst [2];
		int k = 0;
		logic [15:0] c;
		c = ref_crc(n);
		rx_mode = 0;
		stall = stl;
		for (int i = 0; i < n; i++) bcc_framer_i.send(msg[i], i == n - 1);
		bcc_framer_i.drop();
		// Sample mid-cycle what the design and the drain show for the next edge.
		repeat (20) begin
			@(negedge mclk);
			if (ce === 1'b1 && ck_valid === 1'b1 && ck_ready === 1'b1 && k < 2) begin
				got[k] = ck_byte;
				lst[k] = ck_last;
				k++;
			end
		end
		@(posedge mclk);
		#1;
		chk(k == 2, "check bytes missing");
		chk(got[0] === c[7:0], "first check byte");
		chk(got[1] === c[15:8], "second check byte");
		chk(lst[1] === 1'b1 && lst[0] === 1'b0, "check last flag");
	endtask
	// Checks a received block whose check word is corrupted by flip.
	task automatic rx_block(input int n, input logic [15:0] flip);
		logic [15:0] c;
		logic [15:0] g;
		g = ref_crc(n);
		c = g ^ flip;
		rx_mode = 1;
		for (int i = 0; i < n; i++) bcc_framer_i.send(msg[i], i == n - 1);
		bcc_framer_i.send(c[7:0], 1'b0);
		bcc_framer_i.send(c[15:8], 1'b0);
		bcc_framer_i.drop();
		repeat (5) if (result.done !== 1'b1) @(posedge mclk);
		chk(result.done === 1'b1, "no result");
		chk(result.word === {<<{g}}, "result word");
		chk(result.err_cmp === (flip != 0), "compare flag");
		chk(result.err_rem === (flip != 0), "remainder flag");
		@(posedge mclk);
		#1;
	endtask
	// Freezes the block with a check byte pending, then lets it drain.
	task automatic ce_freeze;
		logic [15:0] c;
		c = ref_crc(2);
		rx_mode = 0;
		stall = 0;
		bcc_framer_i.send(msg[0], 1'b0);
		bcc_framer_i.send(msg[1], 1'b1);
		bcc_framer_i.drop();
		ce = 0;
		repeat (3) @(posedge mclk);
		#1;
		chk(ck_valid === 1'b1 && ck_byte === c[7:0], "frozen check byte");
		ce = 1;
		repeat (4) @(posedge mclk);
		#1;
		chk(ck_valid === 1'b0, "no drain after freeze");
	endtask
	task automatic print_verdict;
		$display("mismatches %0d checks %0d", n_mismatch, n_checks);
		if (n_mismatch == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Main sequence.
	initial begin
		repeat (12) @(posedge mclk);
		#1 srst = 0;
		chk(in_ready === 1'b1 && ck_valid === 1'b0, "reset outputs");
		tx_block(6, 0);
		tx_block(1, 1);
		rx_block(6, 16'h0000);
		rx_block(6, 16'h0100);
		rx_block(3, 16'hFFFF);
		tx_block(4, 1);
		ce_freeze();
		print_verdict();
	end
	// Watchdog.
	initial begin
		#300000;
		n_mismatch++;
		print_verdict();
	end
endmodule
